/* File: core/fwsp_pkg.sv */
// Package for the flash write status poller: constants, states, carriers
package fwsp_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 22;
	// Bit positions in the flash data bus
	localparam int POS_POLARITY = 7;
	localparam int POS_BUSY_TOGGLE = 6;
	localparam int POS_TIMING_LIMIT = 5;
	localparam int POS_ERASE_WINDOW = 3;
	localparam int POS_SECTOR_TOGGLE = 2;
	// Register offsets of the host register port
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_ADDR = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
	localparam logic [3:0] OFS_IRQ_CLR = 4'h4;
	localparam logic [3:0] OFS_IRQ_EN = 4'h5;
	localparam logic [3:0] OFS_LAST_DATA = 4'h6;
	// Control bits
	localparam int CTRL_START = 0;
	localparam int CTRL_ABORT = 1;
	localparam int CTRL_SECTOR_CMD = 2;
	// Interrupt bits
	localparam int IRQ_N = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_WINDOW = 2;
	localparam int IRQ_PAUSE = 3;
	// Command words
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	// Bus timing: read and write strobe widths
	localparam int CLK_MHZ = 250;
	localparam int T_STROBE_NS = 70;
	localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_GAP_NS = 30;
	localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;
	// Sector erase window between additional commands
	localparam int T_WINDOW_US = 50;
	localparam int WINDOW_CYC = T_WINDOW_US * CLK_MHZ;
	localparam int DEF_POLL_LIMIT = 64;

	typedef enum logic [7:0] {
		FWSP_IDLE = 8'h01,
		FWSP_READ_FIRST = 8'h02,
		FWSP_READ_SECOND = 8'h04,
		FWSP_CHECK_LIMIT = 8'h08,
		FWSP_RECHECK = 8'h10,
		FWSP_RESET_CMD = 8'h20,
		FWSP_DONE = 8'h40,
		FWSP_FAIL = 8'h80
	} fwsp_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} fwsp_reg_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} fwsp_bus_req_t;
endpackage

/* File: core/fwsp_sync.sv */
// Two-flop synchroniser for flash pin inputs
`timescale 1ns/1ps
module fwsp_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d_in;
			q_reg <= meta_reg;
		end
	end
	assign q_out = q_reg;
endmodule

/* File: core/fwsp_bus_cycle.sv */
// Asynchronous flash bus cycle engine: one read or write per request
`timescale 1ns/1ps
module fwsp_bus_cycle #(
	parameter int STROBE_CYC = fwsp_pkg::STROBE_CYC,
	parameter int GAP_CYC = fwsp_pkg::GAP_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire fwsp_pkg::fwsp_bus_req_t req_in,
	output logic busy_out,
	output logic done_out,
	output logic [fwsp_pkg::DATA_W-1:0] rdata_out,
	input wire logic [fwsp_pkg::DATA_W-1:0] flash_data_sync_in,
	output logic [fwsp_pkg::ADDR_W-1:0] flash_addr_out,
	output logic [fwsp_pkg::DATA_W-1:0] flash_data_out,
	output logic flash_data_oe_n_out,
	output logic flash_ce_n_out,
	output logic flash_oe_n_out,
	output logic flash_we_n_out
);
	// Strobe, then sync settle (2), then gap
	localparam int TOTAL = STROBE_CYC + 2 + GAP_CYC;
	localparam int CW = $clog2(TOTAL + 1);
	logic [CW-1:0] cnt_reg;
	logic active_reg;
	logic is_rd_reg;
	logic [fwsp_pkg::DATA_W-1:0] rdata_reg;
	logic [fwsp_pkg::ADDR_W-1:0] addr_reg;
	logic [fwsp_pkg::DATA_W-1:0] wdata_reg;
	logic done_reg;
	wire start = !active_reg && (req_in.rd || req_in.wr);
	wire in_strobe = active_reg && (cnt_reg < CW'(STROBE_CYC));
	wire sample = active_reg && (cnt_reg == CW'(STROBE_CYC + 1));
	wire last = active_reg && (cnt_reg == CW'(TOTAL - 1));

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt_reg <= '0;
			active_reg <= 1'b0;
			is_rd_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= last;
			if (start) begin
				active_reg <= 1'b1;
				cnt_reg <= '0;
				is_rd_reg <= req_in.rd;
				addr_reg <= req_in.addr;
				wdata_reg <= req_in.wdata;
			end else if (last) begin
				active_reg <= 1'b0;
			end else if (active_reg) begin
				cnt_reg <= cnt_reg + CW'(1);
			end
		end
	end

	// Data captured two cycles after strobe end, clear of pin latency
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_reg <= '0;
		end else if (sample && is_rd_reg) begin
			rdata_reg <= flash_data_sync_in;
		end
	end

	// Read data held on bus until sample; strobe edge data already synced
	assign busy_out = active_reg;
	assign done_out = done_reg;
	assign rdata_out = rdata_reg;
	assign flash_addr_out = addr_reg;
	assign flash_data_out = wdata_reg;
	assign flash_data_oe_n_out = !(active_reg && !is_rd_reg);
	assign flash_ce_n_out = !active_reg;
	assign flash_oe_n_out = !(active_reg && is_rd_reg && cnt_reg <= CW'(STROBE_CYC + 1));
	assign flash_we_n_out = !(in_strobe && !is_rd_reg);
endmodule

/* File: core/fwsp_poller.sv */
// Host-side flash write status poller with register port and interrupt
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module fwsp_poller #(
	parameter int POLL_LIMIT = fwsp_pkg::DEF_POLL_LIMIT,
	parameter int WINDOW_CYC = fwsp_pkg::WINDOW_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic irq_out,
	input wire logic [fwsp_pkg::DATA_W-1:0] flash_data_in,
	output logic [fwsp_pkg::DATA_W-1:0] flash_data_out,
	output logic flash_data_oe_n_out,
	output logic [fwsp_pkg::ADDR_W-1:0] flash_addr_out,
	output logic flash_ce_n_out,
	output logic flash_oe_n_out,
	output logic flash_we_n_out,
	input wire logic ready_busy_output_in
);
	localparam int PW = $clog2(POLL_LIMIT + 1);
	localparam int WW = $clog2(WINDOW_CYC + 1);

	fwsp_pkg::fwsp_reg_req_t reg_req;
	assign reg_req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

	fwsp_pkg::fwsp_state_t state_reg;
	fwsp_pkg::fwsp_state_t state_next;
	logic [fwsp_pkg::ADDR_W-1:0] poll_addr_reg;
	logic [fwsp_pkg::DATA_W-1:0] first_reg;
	logic [fwsp_pkg::DATA_W-1:0] last_reg;
	logic [PW-1:0] polls_reg;
	logic [WW-1:0] window_reg;
	logic [fwsp_pkg::IRQ_N-1:0] irq_stat_reg;
	logic [fwsp_pkg::IRQ_N-1:0] irq_en_reg;
	logic [31:0] rdata_reg;
	logic window_flag_reg;
	logic issued_reg;
	logic [fwsp_pkg::DATA_W-1:0] data_sync;
	logic ready_sync;
	logic cyc_busy;
	logic cyc_done;
	logic cyc_done_raw;
	logic [fwsp_pkg::DATA_W-1:0] cyc_rdata;
	fwsp_pkg::fwsp_bus_req_t cyc_req;

	fwsp_sync #(.W(fwsp_pkg::DATA_W + 1)) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.d_in({ready_busy_output_in, flash_data_in}),
		.q_out({ready_sync, data_sync})
	);

	fwsp_bus_cycle u_cycle (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.req_in(cyc_req),
		.busy_out(cyc_busy),
		.done_out(cyc_done_raw),
		.rdata_out(cyc_rdata),
		.flash_data_sync_in(data_sync),
		.flash_addr_out(flash_addr_out),
		.flash_data_out(flash_data_out),
		.flash_data_oe_n_out(flash_data_oe_n_out),
		.flash_ce_n_out(flash_ce_n_out),
		.flash_oe_n_out(flash_oe_n_out),
		.flash_we_n_out(flash_we_n_out)
	);

	// Late answer of an abandoned cycle is dropped
	assign cyc_done = cyc_done_raw && issued_reg;

	// Register decode
	wire wr_ctrl = reg_req.wr && reg_req.addr == fwsp_pkg::OFS_CTRL;
	wire wr_addr = reg_req.wr && reg_req.addr == fwsp_pkg::OFS_ADDR;
	wire wr_clr = reg_req.wr && reg_req.addr == fwsp_pkg::OFS_IRQ_CLR;
	wire wr_en = reg_req.wr && reg_req.addr == fwsp_pkg::OFS_IRQ_EN;
	wire cmd_start = wr_ctrl && reg_req.wdata[fwsp_pkg::CTRL_START];
	wire cmd_abort = wr_ctrl && reg_req.wdata[fwsp_pkg::CTRL_ABORT];
	wire cmd_sector = wr_ctrl && reg_req.wdata[fwsp_pkg::CTRL_SECTOR_CMD];

	// Status bit views of the read words
	wire tog_first = first_reg[fwsp_pkg::POS_BUSY_TOGGLE];
	wire tog_new = cyc_rdata[fwsp_pkg::POS_BUSY_TOGGLE];
	wire toggling = tog_first != tog_new;
	wire limit_hit = cyc_rdata[fwsp_pkg::POS_TIMING_LIMIT];
	wire window_now = cyc_rdata[fwsp_pkg::POS_ERASE_WINDOW];
	wire poll_busy = state_reg != fwsp_pkg::FWSP_IDLE &&
		state_reg != fwsp_pkg::FWSP_DONE && state_reg != fwsp_pkg::FWSP_FAIL;
	wire poll_exhausted = polls_reg == PW'(POLL_LIMIT);
	wire want_read = state_reg == fwsp_pkg::FWSP_READ_FIRST ||
		state_reg == fwsp_pkg::FWSP_READ_SECOND || state_reg == fwsp_pkg::FWSP_RECHECK;
	wire want_write = state_reg == fwsp_pkg::FWSP_RESET_CMD;
	wire launch = (want_read || want_write) && !cyc_busy && !issued_reg;

	// Reads go to the programmed or erasing address, in the busy bank
	always_comb begin
		cyc_req.addr = poll_addr_reg;
		cyc_req.wdata = fwsp_pkg::CMD_RESET;
		cyc_req.rd = launch && want_read;
		cyc_req.wr = launch && want_write;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			fwsp_pkg::FWSP_IDLE, fwsp_pkg::FWSP_DONE, fwsp_pkg::FWSP_FAIL: begin
				if (cmd_start) begin
					state_next = fwsp_pkg::FWSP_READ_FIRST;
				end
			end
			fwsp_pkg::FWSP_READ_FIRST: begin
				if (cyc_done) begin
					state_next = fwsp_pkg::FWSP_READ_SECOND;
				end
			end
			fwsp_pkg::FWSP_READ_SECOND: begin
				if (cyc_done) begin
					if (!toggling) begin
						state_next = fwsp_pkg::FWSP_DONE;
					end else if (limit_hit) begin
						state_next = fwsp_pkg::FWSP_RECHECK;
					end else if (poll_exhausted) begin
						state_next = fwsp_pkg::FWSP_IDLE;
					end else begin
						state_next = fwsp_pkg::FWSP_CHECK_LIMIT;
					end
				end
			end
			fwsp_pkg::FWSP_CHECK_LIMIT: begin
				state_next = fwsp_pkg::FWSP_READ_SECOND;
			end
			fwsp_pkg::FWSP_RECHECK: begin
				if (cyc_done) begin
					if (toggling) begin
						state_next = fwsp_pkg::FWSP_RESET_CMD;
					end else begin
						state_next = fwsp_pkg::FWSP_DONE;
					end
				end
			end
			fwsp_pkg::FWSP_RESET_CMD: begin
				if (cyc_done) begin
					state_next = fwsp_pkg::FWSP_FAIL;
				end
			end
			default: begin
				state_next = fwsp_pkg::FWSP_IDLE;
			end
		endcase
		if (cmd_abort && poll_busy && state_reg != fwsp_pkg::FWSP_RESET_CMD) begin
			state_next = fwsp_pkg::FWSP_IDLE;
		end
	end

	// Sticky events: set wins over clear
	wire ev_done = state_reg != fwsp_pkg::FWSP_DONE && state_next == fwsp_pkg::FWSP_DONE;
	wire ev_fail = state_reg != fwsp_pkg::FWSP_FAIL && state_next == fwsp_pkg::FWSP_FAIL;
	wire ev_pause = poll_busy && state_next == fwsp_pkg::FWSP_IDLE;
	wire window_seen = state_reg == fwsp_pkg::FWSP_READ_SECOND && cyc_done && window_now;
	wire ev_window = window_seen && !window_flag_reg;
	wire [fwsp_pkg::IRQ_N-1:0] ev_vec = {ev_pause, ev_window, ev_fail, ev_done};

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_reg <= fwsp_pkg::FWSP_IDLE;
			issued_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg || cyc_done) begin
				issued_reg <= 1'b0;
			end else if (launch) begin
				issued_reg <= 1'b1;
			end
		end
	end

	// First read kept for toggle comparison; later reads slide it
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			first_reg <= '0;
			last_reg <= '0;
			polls_reg <= '0;
		end else begin
			if (cyc_done && want_read) begin
				first_reg <= cyc_rdata;
				last_reg <= cyc_rdata;
			end
			if (cmd_start) begin
				polls_reg <= '0;
			end else if (state_reg == fwsp_pkg::FWSP_CHECK_LIMIT) begin
				polls_reg <= polls_reg + PW'(1);
			end
		end
	end

	// Software-side window timer; expiry means window may have closed
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			window_reg <= '0;
			window_flag_reg <= 1'b0;
		end else begin
			if (cmd_sector) begin
				window_reg <= WW'(WINDOW_CYC);
				window_flag_reg <= 1'b0;
			end else if (window_reg != '0) begin
				window_reg <= window_reg - WW'(1);
			end
			if (window_seen) begin
				window_flag_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			poll_addr_reg <= '0;
			irq_stat_reg <= '0;
			irq_en_reg <= '0;
		end else begin
			if (wr_addr && !poll_busy) begin
				poll_addr_reg <= reg_req.wdata[fwsp_pkg::ADDR_W-1:0];
			end
			if (wr_en) begin
				irq_en_reg <= reg_req.wdata[fwsp_pkg::IRQ_N-1:0];
			end
			irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? reg_req.wdata[fwsp_pkg::IRQ_N-1:0] : '0))
				| ev_vec;
		end
	end

	wire [31:0] status_word = {20'h00000, window_reg != '0, ready_sync, window_flag_reg,
		state_reg == fwsp_pkg::FWSP_FAIL, state_reg == fwsp_pkg::FWSP_DONE, poll_busy,
		6'(polls_reg)};
	wire [31:0] rd_mux =
		reg_req.addr == fwsp_pkg::OFS_ADDR ? {10'h000, poll_addr_reg} :
		reg_req.addr == fwsp_pkg::OFS_STATUS ? status_word :
		reg_req.addr == fwsp_pkg::OFS_IRQ_STAT ? {28'h0000000, irq_stat_reg} :
		reg_req.addr == fwsp_pkg::OFS_IRQ_EN ? {28'h0000000, irq_en_reg} :
		reg_req.addr == fwsp_pkg::OFS_LAST_DATA ? {16'h0000, last_reg} : 32'h00000000;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= reg_req.rd ? rd_mux : 32'h00000000;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign irq_out = |(irq_stat_reg & irq_en_reg);
endmodule

/* File: tb/fwsp_poller_props.sv */
// Concurrent checks on the flash status poller ports
`timescale 1ns/1ps
module fwsp_poller_props #(
	parameter int POLL_LIMIT = fwsp_pkg::DEF_POLL_LIMIT,
	parameter int WINDOW_CYC = fwsp_pkg::WINDOW_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic irq_out,
	input wire logic [15:0] flash_data_in,
	input wire logic [15:0] flash_data_out,
	input wire logic flash_data_oe_n_out,
	input wire logic [21:0] flash_addr_out,
	input wire logic flash_ce_n_out,
	input wire logic flash_oe_n_out,
	input wire logic flash_we_n_out,
	input wire logic ready_busy_output_in
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_idle_after_reset: assert property ($fell(rst_in) |->
		flash_ce_n_out && flash_oe_n_out && flash_we_n_out && !irq_out) else $error("not idle");
	a_read_in_select: assert property (!flash_oe_n_out |->
		!flash_ce_n_out && flash_we_n_out && flash_data_oe_n_out) else $error("bad read");
	a_read_length: assert property ($fell(flash_oe_n_out) |->
		!flash_oe_n_out [*8] ##12 !flash_oe_n_out ##1 flash_oe_n_out) else $error("read len");
	a_write_length: assert property ($fell(flash_we_n_out) |->
		!flash_we_n_out [*8] ##10 !flash_we_n_out ##1 flash_we_n_out) else $error("write len");
	a_write_is_reset: assert property ($fell(flash_we_n_out) |-> !flash_data_oe_n_out &&
		flash_data_out == fwsp_pkg::CMD_RESET) else $error("bad command");
	a_addr_held: assert property (!flash_ce_n_out && !$fell(flash_ce_n_out) |->
		$stable(flash_addr_out)) else $error("address moved");
	a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("stray read data");
	a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > fwsp_pkg::OFS_LAST_DATA |=>
		reg_rdata_out == 32'h0) else $error("unmapped read");
	a_irq_masked: assert property (reg_wr_in && reg_addr_in == fwsp_pkg::OFS_IRQ_EN &&
		reg_wdata_in[3:0] == 4'h0 |=> !irq_out) else $error("masked irq");
	c_reset_cmd: cover property ($fell(flash_we_n_out));
	c_irq: cover property ($rose(irq_out));
	c_unmapped: cover property (reg_rd_in && reg_addr_in > fwsp_pkg::OFS_LAST_DATA);
endmodule
bind fwsp_poller fwsp_poller_props #(.POLL_LIMIT(POLL_LIMIT), .WINDOW_CYC(WINDOW_CYC))
	fwsp_poller_props_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
	.flash_data_in(flash_data_in), .flash_data_out(flash_data_out),
	.flash_data_oe_n_out(flash_data_oe_n_out), .flash_addr_out(flash_addr_out),
	.flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
	.flash_we_n_out(flash_we_n_out), .ready_busy_output_in(ready_busy_output_in));

/* File: tb/fwsp_flash_model.sv */
// Behavioural flash device answering status polls
`timescale 1ns/1ps
module fwsp_flash_model (
	input wire logic [21:0] addr_in,
	input wire logic [15:0] data_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	output logic [15:0] data_out,
	output logic ready_busy_output_out
);
	int left = 0;
	int rd_cnt = 0;
	int wr_cnt = 0;
	logic busy = 1'b0;
	logic limit = 1'b0;
	logic erase = 1'b0;
	logic window = 1'b0;
	logic [21:0] busy_addr = 22'h0;
	logic [21:0] last_addr = 22'h0;
	logic [15:0] prog = 16'h0;
	logic [15:0] stat = 16'h0;
	logic [15:0] last_wr = 16'h0;
	logic [15:0] word;
	wire hit = busy && addr_in[21:20] == busy_addr[21:20];
	always_comb begin
		word = prog;
		if (hit) begin
			word[7] = erase ? 1'b0 : ~prog[7];
			word[6] = stat[6];
			word[5] = limit;
			word[3] = erase && window;
			word[2] = erase ? stat[2] : prog[2];
		end
	end
	// Released bus shows the inverse, never a held value
	assign data_out = (!ce_n_in && !oe_n_in) ? word : ~word;
	assign ready_busy_output_out = !busy;
	always @(posedge oe_n_in) begin
		if (!ce_n_in) begin
			rd_cnt++;
			last_addr = addr_in;
			if (busy && left > 0) begin
				stat[6] = ~stat[6];
				stat[2] = ~stat[2];
				left--;
			end else begin
				busy = 1'b0;
			end
		end
	end
	always @(posedge we_n_in) begin
		if (!ce_n_in) begin
			wr_cnt++;
			last_wr = data_in;
			if (data_in === fwsp_pkg::CMD_RESET) begin
				busy = 1'b0;
				limit = 1'b0;
			end
		end
	end
endmodule

/* File: tb/fwsp_poller_tb_top.sv */
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
module fwsp_poller_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] r_addr = 4'h0;
	logic [31:0] r_wdata = 32'h0;
	logic r_wr = 1'b0;
	logic r_rd = 1'b0;
	logic [31:0] r_rdata;
	logic irq;
	logic [15:0] m_dq;
	logic [15:0] h_dq;
	logic h_oe_n;
	logic [21:0] f_addr;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic rdy;
	int error_cnt = 0;
	int cmp_count = 0;
	int k;
	logic [31:0] seed = 32'h00013EEE;
	logic [31:0] v;
	logic [21:0] a;
	wire [15:0] dq = h_oe_n ? m_dq : h_dq;
	fwsp_poller #(.POLL_LIMIT(4), .WINDOW_CYC(20)) fwsp_poller_inst (.clk_sys_in(clk),
		.rst_in(rst), .reg_addr_in(r_addr), .reg_wdata_in(r_wdata), .reg_wr_in(r_wr),
		.reg_rd_in(r_rd), .reg_rdata_out(r_rdata), .irq_out(irq), .flash_data_in(dq),
		.flash_data_out(h_dq), .flash_data_oe_n_out(h_oe_n), .flash_addr_out(f_addr),
		.flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
		.ready_busy_output_in(rdy));
	fwsp_flash_model fwsp_flash_model_inst (.addr_in(f_addr), .data_in(dq), .ce_n_in(ce_n),
		.oe_n_in(oe_n), .we_n_in(we_n), .data_out(m_dq), .ready_busy_output_out(rdy));
	initial begin
		forever #2 clk = ~clk;
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		r_addr <= ad;
		r_wdata <= d;
		r_wr <= 1'b1;
		@(posedge clk);
		r_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [3:0] ad, output logic [31:0] d);
		@(posedge clk);
		r_addr <= ad;
		r_rd <= 1'b1;
		@(posedge clk);
		r_rd <= 1'b0;
		#1 d = r_rdata;
	endtask
	task rc(input logic [3:0] ad, input logic [31:0] exp);
		rd(ad, v);
		chk(v, exp);
	endtask
	// One status poll: device toggles kk times, df is expected {fail, done}
	task poll(input int kk, input logic lim, input logic ers, input logic [1:0] df, input int n);
		int r0;
		int i;
		r0 = fwsp_flash_model_inst.rd_cnt;
		fwsp_flash_model_inst.left = kk;
		fwsp_flash_model_inst.limit = lim;
		fwsp_flash_model_inst.erase = ers;
		fwsp_flash_model_inst.window = ers;
		fwsp_flash_model_inst.busy = 1'b1;
		wr(fwsp_pkg::OFS_CTRL, 32'h1);
		v = 32'h40;
		i = 0;
		while (v[6] !== 1'b0 && i < 400) begin
			rd(fwsp_pkg::OFS_STATUS, v);
			i++;
		end
		chk({30'h0, v[8:7]}, {30'h0, df});
		if (n > 0) chk(fwsp_flash_model_inst.rd_cnt - r0, n);
	endtask
	task close_out();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rc(fwsp_pkg::OFS_IRQ_EN, 32'h0);
		rc(4'h7, 32'h0);
		rc(4'hF, 32'h0);
		rc(fwsp_pkg::OFS_STATUS, 32'h400);
		wr(fwsp_pkg::OFS_IRQ_EN, 32'hF);
		rc(fwsp_pkg::OFS_IRQ_EN, 32'hF);
		v = xs();
		a = v[21:0];
		fwsp_flash_model_inst.busy_addr = a;
		wr(fwsp_pkg::OFS_ADDR, {10'h0, a});
		rc(fwsp_pkg::OFS_ADDR, {10'h0, a});
		v = xs();
		k = int'(v[17:16]);
		fwsp_flash_model_inst.prog = {v[15:7], v[16], v[5:0]};
		poll(k, 1'b0, 1'b0, 2'b01, k + 2);
		chk({10'h0, fwsp_flash_model_inst.last_addr}, {10'h0, a});
		chk({31'h0, irq}, 32'h1);
		wr(fwsp_pkg::OFS_IRQ_EN, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(fwsp_pkg::OFS_IRQ_CLR, 32'hF);
		rc(fwsp_pkg::OFS_IRQ_STAT, 32'h0);
		wr(fwsp_pkg::OFS_IRQ_EN, 32'hF);
		fwsp_flash_model_inst.prog[6] = fwsp_flash_model_inst.stat[6] ^ 1'b1;
		poll(1, 1'b1, 1'b0, 2'b01, 3);
		poll(60, 1'b1, 1'b0, 2'b10, 3);
		chk(fwsp_flash_model_inst.wr_cnt, 1);
		chk({16'h0, fwsp_flash_model_inst.last_wr}, {16'h0, fwsp_pkg::CMD_RESET});
		rc(fwsp_pkg::OFS_IRQ_STAT, 32'h3);
		wr(fwsp_pkg::OFS_IRQ_CLR, 32'hF);
		poll(200, 1'b0, 1'b0, 2'b00, 0);
		rc(fwsp_pkg::OFS_IRQ_STAT, 32'h8);
		wr(fwsp_pkg::OFS_IRQ_CLR, 32'hF);
		wr(fwsp_pkg::OFS_CTRL, 32'h1);
		wr(fwsp_pkg::OFS_CTRL, 32'h2);
		rc(fwsp_pkg::OFS_IRQ_STAT, 32'h8);
		rc(fwsp_pkg::OFS_STATUS, 32'h0);
		// Let the abandoned bus cycle run out
		repeat (40) @(posedge clk);
		fwsp_flash_model_inst.prog[6] = fwsp_flash_model_inst.stat[6];
		poll(0, 1'b0, 1'b0, 2'b01, 2);
		wr(fwsp_pkg::OFS_IRQ_CLR, 32'hF);
		fwsp_flash_model_inst.prog[6] = fwsp_flash_model_inst.stat[6];
		poll(2, 1'b0, 1'b1, 2'b01, 4);
		chk({31'h0, v[9]}, 32'h1);
		rc(fwsp_pkg::OFS_IRQ_STAT, 32'h5);
		wr(fwsp_pkg::OFS_CTRL, 32'h4);
		rd(fwsp_pkg::OFS_STATUS, v);
		chk({31'h0, v[11]}, 32'h1);
		repeat (25) @(posedge clk);
		rd(fwsp_pkg::OFS_STATUS, v);
		chk({31'h0, v[11]}, 32'h0);
		close_out();
	end
endmodule
